/* File: logic/an_status_pkg.sv */
// Constants, field layouts and carrier types for the next-page and expansion status block.
// Contract
// - Hardware alone drives received acknowledge bit.
// - Bit 13 shows message or unformatted page.
// - Bit 12 shows partner can comply.
// - Bit 11 holds received toggle value.
// - Bits 10:0 hold received code field.
// - Expansion bits 15:5 ignore writes, read zero.
// - Bit 4 reports parallel detection fault.
// - Bit 3 reports partner next-page support.
// - Bit 2 reads one permanently.
// - Bit 1 sets on page, clears on read.
// - Bit 0 reports partner negotiation support.
// - Partner word at index 0x05, bits 15/14.
package an_status_pkg;

	// ---------------------------------------------------------------
	// Register indices; byte address is four times the index.
	// ---------------------------------------------------------------
	localparam logic [3:0] IDX_PARTNER_NP = 4'h5;
	localparam logic [3:0] IDX_EXPANSION = 4'h6;
	localparam logic [3:0] IDX_IRQ_STATUS = 4'h8;
	localparam logic [3:0] IDX_IRQ_MASK = 4'h9;
	localparam int ADDR_W = 6;
	localparam int IDX_LSB = 2;

	// ---------------------------------------------------------------
	// Expansion field positions and reset values.
	// ---------------------------------------------------------------
	localparam int EXP_PD_FAULT = 4;
	localparam int EXP_PARTNER_NP = 3;
	localparam int EXP_LOCAL_NP = 2;
	localparam int EXP_PAGE_RX = 1;
	localparam int EXP_PARTNER_AN = 0;
	localparam logic EXP_LOCAL_NP_RESET = 1'b1;
	localparam logic [4:0] EXP_STATUS_RESET = 5'h00;

	// ---------------------------------------------------------------
	// Interrupt status bit positions, width and reset values.
	// ---------------------------------------------------------------
	localparam int IRQ_W = 2;
	localparam int IRQ_PAGE = 0;
	localparam int IRQ_FAULT = 1;
	localparam logic [1:0] IRQ_RESET = 2'h0;

	// Partner next-page word, laid out exactly as software reads it.
	typedef struct packed {
		logic more_pages_request;
		logic ack;
		logic message_page_flag;
		logic comply_acknowledge;
		logic toggle;
		logic [10:0] code;
	} np_word_t;

	localparam np_word_t NP_WORD_RESET = 16'h0000;

	// Level status delivered by the negotiation state machine.
	typedef struct packed {
		logic parallel_detect_fault;
		logic partner_extra_page_capable;
		logic partner_negotiation_capable;
	} an_levels_t;

endpackage

/* File: logic/an_status_regs.sv */
// Avalon-MM register bank for partner next-page word, expansion status and interrupts.
//
// The implementer's own choice: the Avalon-MM interface to the registers.
`timescale 1ns/1ps
module an_status_regs
	import an_status_pkg::*;
(
	input wire logic clk,
	input wire logic rst_b,
	input wire logic [ADDR_W-1:0] address,
	input wire logic read,
	input wire logic write,
	input wire logic [31:0] writedata,
	input wire logic [3:0] byteenable,
	output logic [31:0] readdata,
	output logic waitrequest,
	input wire logic page_valid,
	input wire np_word_t page_word,
	input wire an_levels_t an_levels,
	output logic irq
);

	// ---------------------------------------------------------------
	// State
	// ---------------------------------------------------------------
	np_word_t partner_next_page_word;
	logic parallel_detect_fault;
	logic partner_extra_page_capable;
	logic local_extra_page_capable;
	logic page_received;
	logic partner_negotiation_capable;
	logic [IRQ_W-1:0] irq_status;
	logic [IRQ_W-1:0] irq_mask;
	logic next_page_received;
	logic [IRQ_W-1:0] next_irq_status;
	logic [IRQ_W-1:0] irq_events;
	logic fault_rise;

	// ---------------------------------------------------------------
	// Address decode
	// ---------------------------------------------------------------
	wire logic [3:0] idx = address[ADDR_W-1:IDX_LSB];
	wire logic req = read | write;
	wire logic take = req & waitrequest;
	wire logic hit_np = (idx == IDX_PARTNER_NP);
	wire logic hit_exp = (idx == IDX_EXPANSION);
	wire logic hit_ist = (idx == IDX_IRQ_STATUS);
	wire logic hit_imk = (idx == IDX_IRQ_MASK);
	wire logic low_lane = byteenable[0];

	// Reading the expansion word is what clears the page flag.
	wire logic exp_read = take & read & hit_exp;
	wire logic ist_clear = take & write & hit_ist & low_lane;
	wire logic imk_write = take & write & hit_imk & low_lane;

	// Expansion word; the upper bits are constant zero, so writes there have no target.
	wire logic [15:0] exp_word = {11'h000,
		parallel_detect_fault,
		partner_extra_page_capable,
		local_extra_page_capable,
		page_received,
		partner_negotiation_capable};

	// Read mux; unmapped addresses return zero.
	logic [31:0] rd_mux;
	always_comb begin
		rd_mux = 32'h0000_0000;
		if (hit_np) begin
			rd_mux = {16'h0000, partner_next_page_word};
		end else if (hit_exp) begin
			rd_mux = {16'h0000, exp_word};
		end else if (hit_ist) begin
			rd_mux = {30'h0000_0000, irq_status};
		end else if (hit_imk) begin
			rd_mux = {30'h0000_0000, irq_mask};
		end
	end

	// ---------------------------------------------------------------
	// Avalon handshake
	// ---------------------------------------------------------------

	// Every access waits one cycle; the deassertion lasts exactly one cycle, which keeps
	// a held request from being served twice.
	always_ff @(posedge clk) begin
		if (!rst_b) begin
			waitrequest <= 1'b1;
		end else begin
			waitrequest <= !take;
		end
	end

	// Read data is latched together with the read side effect, so data and clear agree.
	always_ff @(posedge clk) begin
		if (!rst_b) begin
			readdata <= 32'h0000_0000;
		end else if (take & read) begin
			readdata <= rd_mux;
		end
	end

	// ---------------------------------------------------------------
	// Partner page word
	// ---------------------------------------------------------------

	// The word, including its acknowledge bit, is only ever loaded from the link.
	page_capture u_page_capture (
		.clk(clk),
		.rst_b(rst_b),
		.page_accept(page_valid),
		.page_word(page_word),
		.partner_next_page_word(partner_next_page_word)
	);

	// ---------------------------------------------------------------
	// Expansion status
	// ---------------------------------------------------------------

	// A page arriving in the very cycle of the clearing read survives it.
	assign next_page_received = page_valid | (page_received & !exp_read);

	// Level bits follow the negotiation machine one cycle behind.
	always_ff @(posedge clk) begin
		if (!rst_b) begin
			parallel_detect_fault <= EXP_STATUS_RESET[EXP_PD_FAULT];
			partner_extra_page_capable <= EXP_STATUS_RESET[EXP_PARTNER_NP];
			partner_negotiation_capable <= EXP_STATUS_RESET[EXP_PARTNER_AN];
			page_received <= EXP_STATUS_RESET[EXP_PAGE_RX];
			local_extra_page_capable <= EXP_LOCAL_NP_RESET;
		end else begin
			parallel_detect_fault <= an_levels.parallel_detect_fault;
			partner_extra_page_capable <= an_levels.partner_extra_page_capable;
			partner_negotiation_capable <= an_levels.partner_negotiation_capable;
			page_received <= next_page_received;
			local_extra_page_capable <= EXP_LOCAL_NP_RESET;
		end
	end

	// ---------------------------------------------------------------
	// Interrupts
	// ---------------------------------------------------------------

	// Fault interrupt fires on the rising edge only, so a stuck fault raises one event.
	assign fault_rise = an_levels.parallel_detect_fault & !parallel_detect_fault;
	assign irq_events = {fault_rise, page_valid};

	// Write one to clear; a new event in the clearing cycle wins.
	assign next_irq_status = irq_events | (irq_status & ~(ist_clear ? writedata[IRQ_W-1:0] :
		IRQ_RESET));

	always_ff @(posedge clk) begin
		if (!rst_b) begin
			irq_status <= IRQ_RESET;
			irq_mask <= IRQ_RESET;
			irq <= 1'b0;
		end else begin
			irq_status <= next_irq_status;
			irq <= |(irq_status & irq_mask);
			if (imk_write) begin
				irq_mask <= writedata[IRQ_W-1:0];
			end
		end
	end

	// ---------------------------------------------------------------
	// Checks
	// ---------------------------------------------------------------
	default clocking cb @(posedge clk); endclocking
	default disable iff (!rst_b);
	// Properties with rst_b in the antecedent gate on the sampled reset: the release
	// edge still resets the flops, although the disable has already lifted by then.

	a_page_sets_flag: assert property (
		page_valid |=> page_received)
		else $error("Page arrival did not set the page flag.");

	a_read_clears_flag: assert property (
		exp_read && !page_valid |=> !page_received)
		else $error("Expansion read did not clear the page flag.");

	a_flag_and_word: assert property (
		$rose(page_received) |-> partner_next_page_word == $past(page_word))
		else $error("Page flag rose without matching partner word.");

	a_exp_reserved_zero: assert property (
		!waitrequest && read && hit_exp |-> readdata[31:5] == 27'h0000000
			&& readdata[EXP_LOCAL_NP] == 1'b1)
		else $error("Expansion read shows bad reserved or local bits.");

	a_exp_write_inert: assert property (
		take && write && hit_exp |=> ##1 exp_word[15:EXP_LOCAL_NP] ==
			{11'h000, $past(an_levels.parallel_detect_fault),
			$past(an_levels.partner_extra_page_capable), 1'b1})
		else $error("Expansion write changed fixed bits.");

	// A fault level shows in the expansion word one cycle later.
	a_fault_follows: assert property (
		rst_b && an_levels.parallel_detect_fault |=> parallel_detect_fault)
		else $error("Fault bit did not follow detection.");

	// Partner ability levels follow the negotiation machine one cycle behind.
	a_partner_levels: assert property (
		rst_b |=> partner_extra_page_capable == $past(an_levels.partner_extra_page_capable)
			&& partner_negotiation_capable == $past(an_levels.partner_negotiation_capable))
		else $error("Partner ability bits wrong.");

	a_np_read_word: assert property (
		!waitrequest && read && hit_np |-> readdata[15:0] == $past(partner_next_page_word))
		else $error("Partner word read back wrong.");

	a_wait_one_cycle: assert property (
		take |=> !waitrequest ##1 waitrequest)
		else $error("Wait request did not drop for exactly one cycle.");

	a_irq_on_page: assert property (
		page_valid && irq_mask[IRQ_PAGE] && !ist_clear |-> ##[1:2] irq)
		else $error("Unmasked page event gave no interrupt.");

	c_page_then_read: cover property (page_valid ##[1:20] exp_read);
	c_page_during_read: cover property (page_valid && exp_read);
	c_fault_irq: cover property (fault_rise && irq_mask[IRQ_FAULT] ##2 irq);

	// ---------------------------------------------------------------
	// Interrupt checks
	// ---------------------------------------------------------------

	// The interrupt pin lags the masked status by exactly one cycle.
	a_irq_tracks: assert property (
		rst_b |=> irq == |($past(irq_status) & $past(irq_mask)))
		else $error("Interrupt pin does not follow masked status.");

	// A page always lands in the page interrupt bit.
	a_ist_page_sets: assert property (
		rst_b && page_valid |=> irq_status[IRQ_PAGE])
		else $error("Page arrival did not set its interrupt bit.");

	// Writing a one clears the page bit when no page competes.
	a_ist_clear_page: assert property (
		rst_b && ist_clear && writedata[IRQ_PAGE] && !page_valid |=> !irq_status[IRQ_PAGE])
		else $error("Interrupt status clear did not take.");

	// A fresh fault edge is never lost, even during a clearing write.
	a_fault_sets_ist: assert property (
		rst_b && fault_rise |=> irq_status[IRQ_FAULT])
		else $error("Fault edge did not set its interrupt bit.");

	// The mask takes the written value.
	a_mask_loads: assert property (
		rst_b && imk_write |=> irq_mask == $past(writedata[IRQ_W-1:0]))
		else $error("Mask write did not land.");

	// Without a write the mask holds, whatever else the bus does.
	a_mask_holds: assert property (
		rst_b && !imk_write |=> $stable(irq_mask))
		else $error("Mask changed without a write.");

	// Status reads back as it stood at the take edge; spare bits stay zero.
	a_ist_read_back: assert property (
		!waitrequest && read && hit_ist |-> readdata[IRQ_W-1:0] == $past(irq_status)
			&& readdata[31:IRQ_W] == 30'h0000_0000)
		else $error("Interrupt status read back wrong.");

	// ---------------------------------------------------------------
	// Read path checks
	// ---------------------------------------------------------------

	// Read data only moves on a taken read, so a slow master still sees it.
	a_readdata_holds: assert property (
		rst_b && !(take && read) |=> $stable(readdata))
		else $error("Read data moved without a read.");

	// The flag is reported as it stood before the clearing read.
	a_exp_read_flag: assert property (
		!waitrequest && read && hit_exp |-> readdata[EXP_PAGE_RX] == $past(page_received))
		else $error("Expansion read lost the page flag.");

	// The partner word occupies only the low half of the bus word.
	a_np_upper_zero: assert property (
		!waitrequest && read && hit_np |-> readdata[31:16] == 16'h0000)
		else $error("Partner word read shows upper bits.");

	// Holes in the map read as zero.
	a_unmapped_zero: assert property (
		!waitrequest && read && !hit_np && !hit_exp && !hit_ist && !hit_imk
			|-> readdata == 32'h0000_0000)
		else $error("Unmapped read returned data.");

	// Between accesses the slave stalls, so a new request is never answered early.
	a_wait_high_idle: assert property (
		rst_b && !take |=> waitrequest)
		else $error("Wait request dropped without a request.");

	// Clearing the page interrupt, and a write to the read-only expansion word.
	c_irq_cleared: cover property (ist_clear && writedata[IRQ_PAGE] ##2 !irq);
	c_exp_write: cover property (take && write && hit_exp);

endmodule

/* File: logic/page_capture.sv */
// Holding register for the last page word accepted from the link partner.
`timescale 1ns/1ps
module page_capture
	import an_status_pkg::*;
(
	input wire logic clk,
	input wire logic rst_b,
	input wire logic page_accept,
	input wire np_word_t page_word,
	output np_word_t partner_next_page_word
);

	// ---------------------------------------------------------------
	// Capture
	// ---------------------------------------------------------------

	// Whole word loads at once so software never sees a torn page.
	always_ff @(posedge clk) begin
		if (!rst_b) begin
			partner_next_page_word <= NP_WORD_RESET;
		end else if (page_accept) begin
			partner_next_page_word <= page_word;
		end
	end

	// ---------------------------------------------------------------
	// Checks
	// ---------------------------------------------------------------
	a_word_loads_page: assert property (@(posedge clk) disable iff (!rst_b)
		page_accept |=> partner_next_page_word == $past(page_word))
		else $error("Partner word did not take the accepted page.");

	a_word_holds_idle: assert property (@(posedge clk) disable iff (!rst_b)
		!page_accept |=> $stable(partner_next_page_word))
		else $error("Partner word changed without a page.");

endmodule

/* File: tb/an_link_partner.sv */
// Behavioural link partner that delivers accepted pages and ability levels.
`timescale 1ns/1ps
module an_link_partner
	import an_status_pkg::*;
(
	input wire logic clk,
	input wire logic send_req,
	input wire np_word_t tx_word,
	input wire an_levels_t tx_levels,
	output np_word_t page_word,
	output logic page_valid,
	output an_levels_t an_levels
);
	// -------------------------------------------------------------
	// Page delivery
	// -------------------------------------------------------------
	// Start idle so the first edges after reset carry no page; one process owns
	// every output. The word inverts between pages, so a stale value never passes
	// as fresh.
	initial begin
		page_valid = 1'b0;
		page_word = 16'h0000;
		an_levels = 3'h0;
		forever begin
			@(posedge clk);
			page_valid <= send_req;
			page_word <= send_req ? tx_word : ~page_word;
			an_levels <= tx_levels;
		end
	end
endmodule

/* File: tb/tb_an_status_regs.sv */
// Self-checking bench for the next-page and expansion status register bank.
`timescale 1ns/1ps
module tb_an_status_regs
	import an_status_pkg::*;
;
	// Each row: page word, levels, and expansion bits 4:0 expected with the flag set.
	typedef struct packed {
		np_word_t w;
		an_levels_t l;
		logic [4:0] e;
	} row_t;
	logic clk;
	logic rst_b;
	logic [ADDR_W-1:0] address;
	logic read;
	logic write;
	logic [31:0] writedata;
	logic [3:0] byteenable;
	logic [31:0] readdata;
	logic [31:0] rd;
	logic waitrequest;
	logic page_valid;
	logic irq;
	logic send_req;
	np_word_t page_word;
	np_word_t tx_word;
	an_levels_t an_levels;
	an_levels_t tx_levels;
	int error_cnt = 0;
	int n_checks = 0;
	// Boundary code values, both page types, each level alone, all levels and none.
	row_t rows[6] = '{'{16'hA7FF, 3'h7, 5'h1F}, '{16'h5000, 3'h0, 5'h06},
		'{16'h0800, 3'h4, 5'h16}, '{16'h2400, 3'h2, 5'h0E}, '{16'h1001, 3'h1, 5'h07},
		'{16'h0000, 3'h0, 5'h06}};

	an_status_regs u_dut (.clk(clk), .rst_b(rst_b), .address(address), .read(read),
		.write(write), .writedata(writedata), .byteenable(byteenable),
		.readdata(readdata), .waitrequest(waitrequest), .page_valid(page_valid),
		.page_word(page_word), .an_levels(an_levels), .irq(irq));
	an_link_partner u_partner (.clk(clk), .send_req(send_req), .tx_word(tx_word),
		.tx_levels(tx_levels), .page_word(page_word), .page_valid(page_valid),
		.an_levels(an_levels));

	// -------------------------------------------------------------
	// Helpers
	// -------------------------------------------------------------
	task conclude;
		$display("checks %0d errors %0d", n_checks, error_cnt);
		if (error_cnt == 0 && n_checks > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask

	task chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
		n_checks++;
		if (seen !== exp) begin
			error_cnt++;
			$display("mismatch %s expected %h seen %h", name, exp, seen);
		end
	endtask

	// One Avalon access; the request is held until waitrequest is sampled low.
	task bus(input logic wr, input logic [5:0] a, input logic [31:0] d,
		output logic [31:0] q);
		int n;
		@(posedge clk);
		address <= a;
		writedata <= d;
		read <= !wr;
		write <= wr;
		n = 0;
		do begin
			@(posedge clk);
			n++;
		end while (waitrequest !== 1'b0 && n < 50);
		chk("bus answer", n < 50, 1'b1);
		q = readdata;
		read <= 1'b0;
		write <= 1'b0;
	endtask

	task send(input np_word_t w, input an_levels_t l);
		@(posedge clk);
		send_req <= 1'b1;
		tx_word <= w;
		tx_levels <= l;
		@(posedge clk);
		send_req <= 1'b0;
		repeat (3) @(posedge clk);
	endtask

	// -------------------------------------------------------------
	// Clock, watchdog and sequence
	// -------------------------------------------------------------
	initial begin
		clk = 1'b0;
		forever #12.5 clk = ~clk;
	end

	// Normal run is well under a thousand cycles.
	initial begin
		#200000;
		error_cnt++;
		conclude();
	end

	initial begin
		rst_b = 1'b0;
		read = 1'b0;
		write = 1'b0;
		address = 6'h00;
		writedata = 32'h0;
		byteenable = 4'hF;
		send_req = 1'b0;
		tx_word = 16'h0000;
		tx_levels = 3'h0;
		repeat (8) @(posedge clk);
		chk("wait in reset", waitrequest, 1'b1);
		chk("readdata in reset", readdata, 32'h0);
		chk("irq in reset", irq, 1'b0);
		rst_b <= 1'b1;
		bus(1'b0, 6'h14, 32'h0, rd);
		chk("word reset", rd, 32'h0);
		bus(1'b0, 6'h18, 32'h0, rd);
		chk("expansion reset", rd, 32'h4);
		bus(1'b0, 6'h3C, 32'h0, rd);
		chk("unmapped", rd, 32'h0);
		foreach (rows[i]) begin
			send(rows[i].w, rows[i].l);
			bus(1'b0, 6'h14, 32'h0, rd);
			chk("partner word", rd, {16'h0, rows[i].w});
			bus(1'b0, 6'h18, 32'h0, rd);
			chk("expansion", rd, {27'h0, rows[i].e});
			bus(1'b0, 6'h18, 32'h0, rd);
			chk("page flag cleared", rd, {27'h0, rows[i].e & 5'h1D});
		end
		// Writes to the read-only words must leave them untouched.
		bus(1'b1, 6'h18, 32'hFFFF, rd);
		bus(1'b1, 6'h14, 32'hFFFF, rd);
		bus(1'b0, 6'h18, 32'h0, rd);
		chk("expansion after write", rd, 32'h4);
		bus(1'b0, 6'h14, 32'h0, rd);
		chk("word after write", rd, 32'h0);
		// Interrupt: clear, unmask, raise, a dropped write, then clear.
		bus(1'b1, 6'h20, 32'h3, rd);
		bus(1'b1, 6'h24, 32'h1, rd);
		send(16'h2001, 3'h0);
		chk("irq raised", irq, 1'b1);
		byteenable <= 4'h0;
		bus(1'b1, 6'h20, 32'h1, rd);
		byteenable <= 4'hF;
		repeat (2) @(posedge clk);
		chk("irq kept", irq, 1'b1);
		bus(1'b1, 6'h20, 32'h1, rd);
		repeat (2) @(posedge clk);
		chk("irq cleared", irq, 1'b0);
		bus(1'b1, 6'h24, 32'h2, rd);
		send(16'h2002, 3'h0);
		chk("irq masked", irq, 1'b0);
		send(16'h2003, 3'h4);
		chk("irq fault", irq, 1'b1);
		bus(1'b0, 6'h20, 32'h0, rd);
		chk("irq status", rd, 32'h3);
		// A second reset in mid-run restores every reset value.
		// Levels drop first: a fault still standing after reset is a fresh edge.
		@(posedge clk);
		rst_b <= 1'b0;
		tx_levels <= 3'h0;
		repeat (2) @(posedge clk);
		rst_b <= 1'b1;
		chk("irq rereset", irq, 1'b0);
		bus(1'b0, 6'h14, 32'h0, rd);
		chk("word rereset", rd, 32'h0);
		bus(1'b0, 6'h20, 32'h0, rd);
		chk("status rereset", rd, 32'h0);
		bus(1'b0, 6'h18, 32'h0, rd);
		chk("expansion rereset", rd, 32'h4);
		conclude();
	end
endmodule
